/* File: src/mqis_pkg.sv */
// Package with register map, state layout and reset values of the pending-flag block.
package mqis_pkg;
    localparam logic [11:0] MQIS_RX_PEND_OFS = 12'h240;
    localparam logic [11:0] MQIS_RX_CLR_OFS = 12'h248;
    localparam logic [11:0] MQIS_TX_PEND_OFS = 12'h250;
    localparam logic [11:0] MQIS_TX_CLR_OFS = 12'h258;
    localparam logic [11:0] MQIS_LSU_PEND_OFS = 12'h260;
    localparam logic [11:0] MQIS_LSU_CLR_OFS = 12'h268;
    localparam int MQIS_QUEUES = 16;
    localparam int MQIS_UNITS = 4;
    localparam int MQIS_EVENTS = 8;
    localparam int MQIS_DONE_BIT = 0;
    localparam logic [15:0] MQIS_Q_ONE = 16'h0001;
    localparam logic [15:0] MQIS_HALF_ZERO = 16'h0000;
    localparam logic [31:0] MQIS_WORD_ZERO = 32'h0000_0000;
    localparam logic [6:0] MQIS_NONDONE_MASK = 7'h7f;

    typedef enum logic [2:0] {
        MQIS_REG_NONE,
        MQIS_REG_RX_PEND,
        MQIS_REG_RX_CLR,
        MQIS_REG_TX_PEND,
        MQIS_REG_TX_CLR,
        MQIS_REG_LSU_PEND,
        MQIS_REG_LSU_CLR
    } mqis_reg_t;

    typedef struct packed {
        logic [15:0] rx_pend;
        logic [15:0] tx_pend;
        logic [31:0] lsu_pend;
        logic [15:0][31:0] rx_cp;
        logic [15:0][31:0] tx_cp;
        logic ack;
        logic [31:0] rdata;
    } mqis_state_t;

    localparam mqis_state_t MQIS_STATE_RST = '0;
endpackage

/* File: src/mqis_intr_status.sv */
// Pending and clear registers for queue and load/store events, Wishbone slave.
`timescale 1ns/10ps
// Behaviour
// RULE1 - rx queue pending at 0x240, upper zero
// RULE2 - rx queue clear at 0x248, reads zero
// RULE3 - software writes last processed descriptor pointer
// RULE4 - rx pending clears only on pointer match; the code also clears it on a write to the pending register at 0x240
// RULE5 - tx queue pending at 0x250, upper zero
// RULE6 - tx queue clear at 0x258, reads zero
// RULE7 - software acknowledges tx after reclaiming descriptors
// RULE8 - tx pending clears only on pointer match; the code also clears it on a write to the pending register at 0x250
// RULE9 - load/store pending at 0x260, all read/write
// RULE10 - load/store clear at 0x268, write only
// RULE11 - bit 0 first unit completion
// RULE12 - bit 1 first unit error response
// RULE13 - bit 2 first unit Xoff
// RULE14 - bit 3 first unit unsupported type
// RULE15 - bit 4 first unit timeout
// RULE16 - bit 5 first unit DMA error
// RULE17 - bit 6 first unit retry or semaphore
// RULE18 - bit 7 first unit no credit
// RULE19 - second unit events in bits 8-15
// RULE20 - third unit events from bit 16
// RULE21 - third unit bits 21 to 23
// RULE22 - fourth unit events in bits 24-31
// RULE23 - completion flag gated by request enable
// RULE24 - writing one clears, zero keeps
module mqis_intr_status
    import mqis_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_desc_done,
    input wire logic [3:0] rx_desc_queue,
    input wire logic [31:0] rx_desc_cp,
    input wire logic rx_sw_cp_wr,
    input wire logic [3:0] rx_sw_cp_queue,
    input wire logic [31:0] rx_sw_cp_value,
    input wire logic tx_desc_done,
    input wire logic [3:0] tx_desc_queue,
    input wire logic [31:0] tx_desc_cp,
    input wire logic tx_sw_cp_wr,
    input wire logic [3:0] tx_sw_cp_queue,
    input wire logic [31:0] tx_sw_cp_value,
    input wire logic [31:0] lsu_event,
    input wire logic [3:0] lsu_intr_req,
    output logic [15:0] rx_pending,
    output logic [15:0] tx_pending,
    output logic [31:0] lsu_pending
);

    logic rst_meta_reg;
    logic rst_n_sync_reg;
    mqis_state_t st_reg;
    mqis_state_t st_next;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    mqis_reg_t acc_reg;
    logic [31:0] byte_mask;
    logic [31:0] lsu_set;
    logic [15:0] rx_set;
    logic [15:0] rx_clr;
    logic [15:0] tx_set;
    logic [15:0] tx_clr;

    function automatic mqis_reg_t mqis_decode(input logic [11:0] adr);
        mqis_reg_t r;
        r = MQIS_REG_NONE;
        if (adr == MQIS_RX_PEND_OFS)
            r = MQIS_REG_RX_PEND;
        else if (adr == MQIS_RX_CLR_OFS)
            r = MQIS_REG_RX_CLR;
        else if (adr == MQIS_TX_PEND_OFS)
            r = MQIS_REG_TX_PEND;
        else if (adr == MQIS_TX_CLR_OFS)
            r = MQIS_REG_TX_CLR;
        else if (adr == MQIS_LSU_PEND_OFS)
            r = MQIS_REG_LSU_PEND;
        else if (adr == MQIS_LSU_CLR_OFS)
            r = MQIS_REG_LSU_CLR;
        return r;
    endfunction

    function automatic logic [15:0] mqis_onehot(input logic [3:0] q);
        return MQIS_Q_ONE << q;
    endfunction

    // The rest of the block sees reset leave only on a clock edge.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_sync_reg <= rst_meta_reg;
        end
    end

    assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign bus_wr = bus_req && wb_we_i;
    assign bus_rd = bus_req && !wb_we_i;
    assign acc_reg = mqis_decode(wb_adr_i);

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_mask
            assign byte_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
        end
    endgenerate

    // Each unit owns one byte, events in the same order in every byte.
    // RULE11 - first unit completion
    // RULE12 - first unit error
    // RULE13 - first unit Xoff
    // RULE14 - first unit unsupported
    // RULE15 - first unit timeout
    // RULE16 - first unit DMA
    // RULE17 - first unit retry
    // RULE18 - first unit credit
    // RULE19 - second unit byte
    // RULE20 - third unit byte
    // RULE21 - third unit upper
    // RULE22 - fourth unit byte
    genvar gu;
    generate
        for (gu = 0; gu < MQIS_UNITS; gu++)
        begin : g_unit
            // RULE23 - completion enable gate
            assign lsu_set[gu*MQIS_EVENTS +: MQIS_EVENTS] = lsu_event[gu*MQIS_EVENTS +: MQIS_EVENTS]
                & {MQIS_NONDONE_MASK, lsu_intr_req[gu]};
        end
    endgenerate

    assign rx_set = rx_desc_done ? mqis_onehot(rx_desc_queue) : MQIS_HALF_ZERO;
    assign tx_set = tx_desc_done ? mqis_onehot(tx_desc_queue) : MQIS_HALF_ZERO;
    // RULE4 - rx pointer match
    assign rx_clr = (rx_sw_cp_wr && rx_sw_cp_value == st_reg.rx_cp[rx_sw_cp_queue])
        ? mqis_onehot(rx_sw_cp_queue) : MQIS_HALF_ZERO;
    // RULE8 - tx pointer match
    assign tx_clr = (tx_sw_cp_wr && tx_sw_cp_value == st_reg.tx_cp[tx_sw_cp_queue])
        ? mqis_onehot(tx_sw_cp_queue) : MQIS_HALF_ZERO;

    always_comb
    begin
        st_next = st_reg;
        st_next.ack = bus_req;
        st_next.rdata = MQIS_WORD_ZERO;
        if (rx_desc_done)
            st_next.rx_cp[rx_desc_queue] = rx_desc_cp;
        if (tx_desc_done)
            st_next.tx_cp[tx_desc_queue] = tx_desc_cp;
        st_next.rx_pend = st_reg.rx_pend & ~rx_clr;
        st_next.tx_pend = st_reg.tx_pend & ~tx_clr;
        st_next.lsu_pend = st_reg.lsu_pend;
        if (bus_wr)
        begin
            // RULE1 - rx pending write
            if (acc_reg == MQIS_REG_RX_PEND)
                st_next.rx_pend = (st_next.rx_pend & ~byte_mask[15:0])
                    | (wb_dat_i[15:0] & byte_mask[15:0]);
            // RULE5 - tx pending write
            else if (acc_reg == MQIS_REG_TX_PEND)
                st_next.tx_pend = (st_next.tx_pend & ~byte_mask[15:0])
                    | (wb_dat_i[15:0] & byte_mask[15:0]);
            // RULE9 - lsu pending write
            else if (acc_reg == MQIS_REG_LSU_PEND)
                st_next.lsu_pend = (st_reg.lsu_pend & ~byte_mask) | (wb_dat_i & byte_mask);
            // RULE10 - lsu clear write
            // RULE24 - ones clear bits
            else if (acc_reg == MQIS_REG_LSU_CLR)
                st_next.lsu_pend = st_reg.lsu_pend & ~(wb_dat_i & byte_mask);
        end
        // A new event in the same cycle as a clear is kept.
        st_next.rx_pend = st_next.rx_pend | rx_set;
        st_next.tx_pend = st_next.tx_pend | tx_set;
        st_next.lsu_pend = st_next.lsu_pend | lsu_set;
        if (bus_rd)
        begin
            // RULE2 - clear reads zero
            // RULE6 - clear reads zero
            if (acc_reg == MQIS_REG_RX_PEND)
                st_next.rdata = {MQIS_HALF_ZERO, st_reg.rx_pend};
            else if (acc_reg == MQIS_REG_TX_PEND)
                st_next.rdata = {MQIS_HALF_ZERO, st_reg.tx_pend};
            else if (acc_reg == MQIS_REG_LSU_PEND)
                st_next.rdata = st_reg.lsu_pend;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_sync_reg)
    begin
        if (!rst_n_sync_reg)
            st_reg <= MQIS_STATE_RST;
        else
            st_reg <= st_next;
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign rx_pending = st_reg.rx_pend;
    assign tx_pending = st_reg.tx_pend;
    assign lsu_pending = st_reg.lsu_pend;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n_sync_reg);

    a_ack_single: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o) // RULE9
        else $error("ack not a single cycle after request");

    a_rx_upper_zero: assert property ( // RULE1
        bus_rd && acc_reg == MQIS_REG_RX_PEND |=> wb_dat_o == {16'h0000, $past(rx_pending)})
        else $error("rx pending read wrong");

    a_rx_clr_reads: assert property ( // RULE2
        bus_rd && acc_reg == MQIS_REG_RX_CLR |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("rx clear read not zero");

    a_tx_upper_zero: assert property ( // RULE5
        bus_rd && acc_reg == MQIS_REG_TX_PEND |=> wb_dat_o[31:16] == 16'h0000)
        else $error("tx pending upper half not zero");

    a_rx_cp_match: assert property ( // RULE4
        rx_clr != 16'h0000 && !rx_desc_done && !bus_wr |=> (rx_pending & $past(rx_clr)) == 16'h0000)
        else $error("rx pending not cleared on match");

    a_rx_cp_miss: assert property ( // RULE4
        rx_sw_cp_wr && rx_clr == 16'h0000 && !bus_wr |=> (rx_pending & $past(rx_pending)) == $past(rx_pending))
        else $error("rx pending cleared without match");

    a_tx_cp_match: assert property ( // RULE8
        tx_clr != 16'h0000 && !tx_desc_done && !bus_wr |=> (tx_pending & $past(tx_clr)) == 16'h0000)
        else $error("tx pending not cleared on match");

    a_lsu_clear_ones: assert property ( // RULE24
        bus_wr && acc_reg == MQIS_REG_LSU_CLR && wb_sel_i == 4'hf && lsu_event == 32'h0000_0000
        |=> lsu_pending == ($past(lsu_pending) & ~$past(wb_dat_i)))
        else $error("lsu clear write wrong");

    a_lsu_done_gate: assert property ( // RULE23
        lsu_event[0] && !lsu_intr_req[0] && !lsu_pending[0] && !bus_wr |=> !lsu_pending[0])
        else $error("completion flag set while disabled");

    a_lsu_event_set: assert property ( // RULE12
        lsu_event[1] |=> lsu_pending[1])
        else $error("error event lost");

    a_lsu_last_set: assert property ( // RULE22
        lsu_event[31] |=> lsu_pending[31])
        else $error("fourth unit credit event lost");

    // Bus side: the answer is a single registered pulse and the data word is quiet otherwise.
    a_ack_idle: assert property ( // RULE9
        !bus_req |=> !wb_ack_o)
        else $error("ack without request");

    a_dat_idle: assert property ( // RULE2
        !bus_rd |=> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_tx_clr_reads: assert property ( // RULE6
        bus_rd && acc_reg == MQIS_REG_TX_CLR |=> wb_dat_o == 32'h0000_0000)
        else $error("tx clear read not zero");

    a_lsu_clr_reads: assert property ( // RULE10
        bus_rd && acc_reg == MQIS_REG_LSU_CLR |=> wb_dat_o == 32'h0000_0000)
        else $error("lsu clear read not zero");

    a_tx_pend_read: assert property ( // RULE5
        bus_rd && acc_reg == MQIS_REG_TX_PEND |=> wb_dat_o == {16'h0000, $past(tx_pending)})
        else $error("tx pending read wrong");

    a_lsu_pend_read: assert property ( // RULE9
        bus_rd && acc_reg == MQIS_REG_LSU_PEND |=> wb_dat_o == $past(lsu_pending))
        else $error("lsu pending read wrong");

    // Register writes load or keep the flags; a same-cycle event is excluded so the value is exact, except in a_lsu_zero_keeps.
    a_rx_pend_write: assert property ( // RULE1
        bus_wr && acc_reg == MQIS_REG_RX_PEND && wb_sel_i == 4'hf && !rx_desc_done
        |=> rx_pending == $past(wb_dat_i[15:0]))
        else $error("rx pending write wrong");

    a_tx_pend_write: assert property ( // RULE5
        bus_wr && acc_reg == MQIS_REG_TX_PEND && wb_sel_i == 4'hf && !tx_desc_done
        |=> tx_pending == $past(wb_dat_i[15:0]))
        else $error("tx pending write wrong");

    a_lsu_pend_write: assert property ( // RULE9
        bus_wr && acc_reg == MQIS_REG_LSU_PEND && wb_sel_i == 4'hf && lsu_event == 32'h0000_0000
        |=> lsu_pending == $past(wb_dat_i))
        else $error("lsu pending write wrong");

    a_rx_clr_noop: assert property ( // RULE2
        bus_wr && acc_reg == MQIS_REG_RX_CLR && !rx_desc_done && !rx_sw_cp_wr
        |=> rx_pending == $past(rx_pending))
        else $error("rx clear write changed flags");

    a_lsu_zero_keeps: assert property ( // RULE24
        bus_wr && acc_reg == MQIS_REG_LSU_CLR && wb_sel_i == 4'hf
        |=> (lsu_pending & ~$past(wb_dat_i)) == ($past(lsu_pending) & ~$past(wb_dat_i)))
        else $error("lsu clear touched a zero bit");

    // Pointer compare and set-beats-clear on the queue flags and the load/store flags.
    a_tx_cp_miss: assert property ( // RULE8
        tx_sw_cp_wr && tx_clr == 16'h0000 && !bus_wr
        |=> (tx_pending & $past(tx_pending)) == $past(tx_pending))
        else $error("tx pending cleared without match");

    a_rx_set_wins: assert property ( // RULE4
        rx_desc_done |=> (rx_pending & $past(rx_set)) == $past(rx_set))
        else $error("rx event lost");

    a_tx_set_wins: assert property ( // RULE8
        tx_desc_done |=> (tx_pending & $past(tx_set)) == $past(tx_set))
        else $error("tx event lost");

    a_lsu_set_all: assert property ( // RULE11
        lsu_set != 32'h0000_0000 |=> (lsu_pending & $past(lsu_set)) == $past(lsu_set))
        else $error("load/store event lost");

    // One check per first-unit event kind but the error bit, then bits 8, 20, 23 and 24 of later units and the third unit's gate.
    a_lsu_done_set: assert property ( // RULE11
        lsu_event[0] && lsu_intr_req[0] |=> lsu_pending[0])
        else $error("enabled completion event lost");

    a_lsu_xoff_set: assert property ( // RULE13
        lsu_event[2] |=> lsu_pending[2])
        else $error("xoff event lost");

    a_lsu_unsup_set: assert property ( // RULE14
        lsu_event[3] |=> lsu_pending[3])
        else $error("unsupported event lost");

    a_lsu_tmo_set: assert property ( // RULE15
        lsu_event[4] |=> lsu_pending[4])
        else $error("timeout event lost");

    a_lsu_dma_set: assert property ( // RULE16
        lsu_event[5] |=> lsu_pending[5])
        else $error("dma event lost");

    a_lsu_retry_set: assert property ( // RULE17
        lsu_event[6] |=> lsu_pending[6])
        else $error("retry event lost");

    a_lsu_credit_set: assert property ( // RULE18
        lsu_event[7] |=> lsu_pending[7])
        else $error("credit event lost");

    a_lsu_unit2_done: assert property ( // RULE19
        lsu_event[8] && lsu_intr_req[1] |=> lsu_pending[8])
        else $error("second unit completion lost");

    a_lsu_unit3_tmo: assert property ( // RULE20
        lsu_event[20] |=> lsu_pending[20])
        else $error("third unit timeout lost");

    a_lsu_unit3_top: assert property ( // RULE21
        lsu_event[23] |=> lsu_pending[23])
        else $error("third unit credit event lost");

    a_lsu_unit4_done: assert property ( // RULE22
        lsu_event[24] && lsu_intr_req[3] |=> lsu_pending[24])
        else $error("fourth unit completion lost");

    a_lsu_gate_unit3: assert property ( // RULE23
        lsu_event[16] && !lsu_intr_req[2] && !lsu_pending[16] && !bus_wr |=> !lsu_pending[16])
        else $error("third unit completion set while disabled");

endmodule

/* File: tb/test_mqis_intr_status.sv */
// Self-checking bench for the queue and load/store pending-flag block.
`timescale 1ns/10ps
module test_mqis_intr_status import mqis_pkg::*;;
logic ref_clk;
logic arst_n;
logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
logic [11:0] wb_adr_i;
logic [3:0] wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, rd_data;
logic rx_desc_done, rx_sw_cp_wr, tx_desc_done, tx_sw_cp_wr;
logic [3:0] rx_desc_queue, rx_sw_cp_queue, tx_desc_queue, tx_sw_cp_queue, lsu_intr_req;
logic [31:0] rx_desc_cp, rx_sw_cp_value, tx_desc_cp, tx_sw_cp_value, lsu_event, lsu_pending;
logic [15:0] rx_pending, tx_pending;
int err_count;
int compares;
int cycles;

mqis_intr_status DUT (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_desc_done(rx_desc_done), .rx_desc_queue(rx_desc_queue), .rx_desc_cp(rx_desc_cp),
    .rx_sw_cp_wr(rx_sw_cp_wr), .rx_sw_cp_queue(rx_sw_cp_queue),
    .rx_sw_cp_value(rx_sw_cp_value), .tx_desc_done(tx_desc_done),
    .tx_desc_queue(tx_desc_queue), .tx_desc_cp(tx_desc_cp), .tx_sw_cp_wr(tx_sw_cp_wr),
    .tx_sw_cp_queue(tx_sw_cp_queue), .tx_sw_cp_value(tx_sw_cp_value),
    .lsu_event(lsu_event), .lsu_intr_req(lsu_intr_req), .rx_pending(rx_pending),
    .tx_pending(tx_pending), .lsu_pending(lsu_pending));

initial
begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
end

task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask

// A hang anywhere ends the run through the same report.
always @(posedge ref_clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        err_count++;
        close_out();
    end
end

task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
        err_count++;
        $display("Error %s expected %h seen %h", name, exp, got);
    end
endtask

// One classic cycle; the request stands until ack is sampled high.
task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do
    begin
        @(posedge ref_clk);
        n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd_data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    chk("bus ack", 32'h1, {31'h0, wb_ack_o});
endtask

task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 4'hf);
endtask

task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0, 4'hf);
    chk("read data", exp, rd_data);
endtask

task automatic lsu_pulse(input logic [31:0] ev, input logic [3:0] req);
    @(posedge ref_clk);
    lsu_event <= ev;
    lsu_intr_req <= req;
    @(posedge ref_clk);
    lsu_event <= 32'h0;
    #1;
endtask

// The extra edge leaves room for a pointer match to land before the check.
task automatic q_pulse(input bit tx, input bit sw, input logic [3:0] q, input logic [31:0] cp,
    input logic [15:0] exp);
    @(posedge ref_clk);
    {tx_desc_done, tx_sw_cp_wr} <= tx ? {!sw, sw} : 2'h0;
    {rx_desc_done, rx_sw_cp_wr} <= tx ? 2'h0 : {!sw, sw};
    {rx_desc_queue, rx_sw_cp_queue, tx_desc_queue, tx_sw_cp_queue} <= {4{q}};
    {rx_desc_cp, rx_sw_cp_value, tx_desc_cp, tx_sw_cp_value} <= {4{cp}};
    @(posedge ref_clk);
    {rx_desc_done, rx_sw_cp_wr, tx_desc_done, tx_sw_cp_wr} <= 4'h0;
    @(posedge ref_clk);
    #1;
    chk("queue pending", {16'h0, exp}, {16'h0, tx ? tx_pending : rx_pending});
endtask

initial
begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {rx_desc_done, rx_sw_cp_wr, tx_desc_done, tx_sw_cp_wr, lsu_intr_req} = '0;
    {rx_desc_queue, rx_sw_cp_queue, tx_desc_queue, tx_sw_cp_queue} = '0;
    {rx_desc_cp, rx_sw_cp_value, tx_desc_cp, tx_sw_cp_value, lsu_event} = '0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 6; i++)
        rd(12'h240 + 12'(8 * i), 32'h0);
    rd(12'h244, 32'h0);
    for (int d = 0; d < 2; d++)
    begin
        q_pulse(d[0], 1'b0, 4'hf, 32'h0000_1234, 16'h8000);
        q_pulse(d[0], 1'b0, 4'h0, 32'h0000_00aa, 16'h8001);
        q_pulse(d[0], 1'b1, 4'hf, 32'h0000_1235, 16'h8001);
        q_pulse(d[0], 1'b1, 4'hf, 32'h0000_00aa, 16'h8001);
        q_pulse(d[0], 1'b1, 4'hf, 32'h0000_1234, 16'h0001);
        wr(d ? MQIS_TX_CLR_OFS : MQIS_RX_CLR_OFS, 32'hffff_ffff);
        rd(d ? MQIS_TX_CLR_OFS : MQIS_RX_CLR_OFS, 32'h0);
        rd(d ? MQIS_TX_PEND_OFS : MQIS_RX_PEND_OFS, 32'h1);
        wr(d ? MQIS_TX_PEND_OFS : MQIS_RX_PEND_OFS, 32'hffff_ffff);
        rd(d ? MQIS_TX_PEND_OFS : MQIS_RX_PEND_OFS, 32'h0000_ffff);
        wr(d ? MQIS_TX_PEND_OFS : MQIS_RX_PEND_OFS, 32'h0);
    end
    for (int i = 0; i < 32; i++)
    begin
        lsu_pulse(32'h1 << i, 4'hf);
        chk("lsu pending", 32'h1 << i, lsu_pending);
        wr(MQIS_LSU_CLR_OFS, 32'h1 << i);
        chk("lsu pending", 32'h0, lsu_pending);
    end
    lsu_pulse(32'hffff_ffff, 4'h0);
    chk("lsu pending", 32'hfefe_fefe, lsu_pending);
    lsu_pulse(32'h0101_0101, 4'h5);
    chk("lsu pending", 32'hfeff_feff, lsu_pending);
    wr(MQIS_LSU_CLR_OFS, 32'h0000_ffff);
    rd(MQIS_LSU_PEND_OFS, 32'hfeff_0000);
    rd(MQIS_LSU_CLR_OFS, 32'h0);
    wr(MQIS_LSU_CLR_OFS, 32'hffff_ffff);
    bus(1'b1, MQIS_LSU_PEND_OFS, 32'hffff_ffff, 4'h2);
    rd(MQIS_LSU_PEND_OFS, 32'h0000_ff00);
    wr(MQIS_LSU_PEND_OFS, 32'hffff_ffff);
    rd(MQIS_LSU_PEND_OFS, 32'hffff_ffff);
    close_out();
end
endmodule
